// [rtl/host_port_pkg.sv]
package host_port_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int DATA_W  = 16;     // Processor data bus width
    localparam int ADDR_W  = 12;     // Processor address width
    localparam int IRQ_W   = 8;      // Internal interrupt sources

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
    localparam logic [1:0]        SYNC_RST = 2'h0;
    localparam logic [2:0]        PIPE_RST = 3'h0;
    // Pin pipeline taps compared for a settled change
    localparam int TAP_MID  = 1;
    localparam int TAP_LAST = 2;

    // ==========================================================
    // Handshake styles
    // ==========================================================
    typedef enum logic {
        STYLE_DIR    = 1'b0,         // Direction line plus tied enable
        STYLE_STROBE = 1'b1          // Separate active-low strobes
    } style_t;

    // ==========================================================
    // Access kinds seen on the pins
    // ==========================================================
    typedef enum logic [2:0] {
        ACC_IDLE  = 3'b001,
        ACC_READ  = 3'b010,
        ACC_WRITE = 3'b100
    } acc_t;

    // Request carried to the internal register side
    typedef struct packed {
        logic              wr_stb;   // One-cycle write pulse
        logic              rd_act;   // Read in progress
        logic [ADDR_W-1:0] addr;     // Target location
        logic [DATA_W-1:0] wdata;    // Write data
    } host_req_t;

    // Control pin group, all after synchronising
    typedef struct packed {
        logic cs_n;
        logic rw_wr_n;               // Direction or write strobe
        logic oe_rd_n;               // Output enable or read strobe
    } ctl_pins_t;

endpackage : host_port_pkg

// [rtl/pin_sync.sv]
// ==============================================================
// Three-stage pin synchroniser with settle check
// ==============================================================
module pin_sync #(
    parameter int W = 1              // Number of pins
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_pin,  // Raw asynchronous pins
    output logic      [W-1:0] o_sync  // Settled level per pin
);

    logic [W-1:0] s1_ff, s2_ff, s3_ff, out_ff;
    logic [W-1:0] nxt_out;

    // Accept a change only when stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
        end
    end

    // Stage one feeds only stage two
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_ff  <= '1;
            s2_ff  <= '1;
            s3_ff  <= '1;
            out_ff <= '1;
        end else begin
            s1_ff  <= i_pin;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            out_ff <= nxt_out;
        end
    end

    assign o_sync = out_ff;

endmodule : pin_sync

// [rtl/host_bus_port.sv]
// What this block does
// R1 - 16-bit data bus, both directions
// R2 - Processor gives 12-bit address
// R3 - Direction style: low writes, high reads
// R4 - Strobe style: low write strobe captures
// R5 - Strobe style: low read strobe returns data
// R6 - Direction style keeps output enable grounded
// R7 - Ignore bus while chip select high
// R8 - Interrupt pin low while any pending
// R9 - Drive data only during selected read
module host_bus_port #(
    parameter int IRQ_N = host_port_pkg::IRQ_W  // Interrupt sources
) (
    input  wire logic                              i_core_clk,
    input  wire logic                              i_rst,
    input  wire logic                              i_style,
    input  wire logic                              i_cs_n,
    input  wire logic                              i_rw_wr_n,
    input  wire logic                              i_oe_rd_n,
    input  wire logic [host_port_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [host_port_pkg::DATA_W-1:0]  i_data,
    input  wire logic [host_port_pkg::DATA_W-1:0]  i_rdata,
    input  wire logic [IRQ_N-1:0]                  i_irq_src,
    output logic      [host_port_pkg::DATA_W-1:0]  o_data,
    output logic                                   o_data_oe,
    output logic                                   o_irq_n,
    output logic                                   o_irq_oe,
    output logic                                   o_wr_stb,
    output logic                                   o_rd_act,
    output logic      [host_port_pkg::ADDR_W-1:0]  o_addr,
    output logic      [host_port_pkg::DATA_W-1:0]  o_wdata
);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    localparam int CW = 3;            // Control pins
    localparam int AW = host_port_pkg::ADDR_W;
    localparam int DW = host_port_pkg::DATA_W;
    // Latency, counted in core clock edges from a pin change:
    //   edges one to three shift the pin through the stages,
    //   edge four moves the settled level to the output flop,
    //   edge five registers the decoded access onto the outputs.
    // So a write pulse or bus enable follows its pins by five edges,
    // and the bus is still driven for five edges after a read ends.
    // The processor must hold each access well beyond that, and
    // leave a gap of two cycles or more between writes.
    // A bit that settles a cycle later than chip select can be
    // caught stale, so address and data must not trail the controls.
    // Trade-off: this costs latency but needs no processor clock.

    logic [CW-1:0]           ctl_sync;        // Settled controls
    host_port_pkg::ctl_pins_t ctl;            // Named control group
    logic [AW-1:0]           addr_sync;       // Settled address
    logic [DW-1:0]           data_sync;       // Settled write data
    logic                    style_sync;      // Settled style strap

    // Controls settle through three stages before use
    pin_sync #(.W(CW)) u_ctl_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_pin      ({i_cs_n, i_rw_wr_n, i_oe_rd_n}),
        .o_sync     (ctl_sync)
    );

    // Address lines follow the same path so they align with controls
    pin_sync #(.W(AW)) u_addr_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_pin      (i_addr),
        .o_sync     (addr_sync)
    );

    // Write data, also aligned with the controls
    pin_sync #(.W(DW)) u_data_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_pin      (i_data),
        .o_sync     (data_sync)
    );

    // Style strap is a pin too, so it takes the same three stages.
    // Its reset level reads as strobe style until the strap settles,
    // which is harmless because chip select also resets to idle.
    pin_sync #(.W(1)) u_style_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_pin      (i_style),
        .o_sync     (style_sync)
    );

    assign ctl = ctl_sync;

    // ==========================================================
    // Access decode
    // ==========================================================
    // Classify the pin state into one access kind
    function automatic host_port_pkg::acc_t decode_acc(
        input logic                  style,
        input host_port_pkg::ctl_pins_t c
    );
        host_port_pkg::acc_t a;
        a = host_port_pkg::ACC_IDLE;
        // R7 chip select gate
        if (!c.cs_n) begin
            if (style == host_port_pkg::STYLE_DIR) begin
                // R3 direction line sense
                // R6 enable grounded, so treated as don't care
                a = c.rw_wr_n ? host_port_pkg::ACC_READ
                              : host_port_pkg::ACC_WRITE;
            end else begin
                // R4 write strobe wins if both low
                if (!c.rw_wr_n) begin
                    a = host_port_pkg::ACC_WRITE;
                // R5 read strobe
                end else if (!c.oe_rd_n) begin
                    a = host_port_pkg::ACC_READ;
                end
            end
        end
        return a;
    endfunction : decode_acc

    host_port_pkg::acc_t acc;        // Current access kind

    // Decode once per cycle from settled pins only
    assign acc = decode_acc(style_sync, ctl);

    // ==========================================================
    // Access state machine
    // ==========================================================
    // The state is only the decoded access of the last cycle; it
    // exists so that a held write produces one pulse, not many.
    host_port_pkg::acc_t st_ff, nxt_st;

    // Follow the pins; a write pulses once on entry
    always_comb begin
        nxt_st = acc;
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= host_port_pkg::ACC_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Outputs to the pins and to the register side
    // ==========================================================
    host_port_pkg::host_req_t req_ff, nxt_req;
    logic [DW-1:0] dout_ff, nxt_dout;
    logic          doe_ff, nxt_doe;
    logic          irq_oe_ff, nxt_irq_oe;
    logic          irq_n_ff, nxt_irq_n;    // Pin level while driven

    // Compute next outputs from the decoded access
    always_comb begin
        nxt_req.addr   = req_ff.addr;
        nxt_req.wdata  = req_ff.wdata;
        nxt_req.wr_stb = 1'b0;
        nxt_req.rd_act = 1'b0;
        nxt_dout       = dout_ff;
        nxt_doe        = 1'b0;
        unique case (acc)
            host_port_pkg::ACC_WRITE: begin
                // R4 capture once per write, on entry
                if (st_ff != host_port_pkg::ACC_WRITE) begin
                    nxt_req.wr_stb = 1'b1;
                    // R2 address selects location
                    nxt_req.addr   = addr_sync;
                    // R1 processor drives data in
                    nxt_req.wdata  = data_sync;
                end
            end
            host_port_pkg::ACC_READ: begin
                nxt_req.rd_act = 1'b1;
                nxt_req.addr   = addr_sync;
                // R1 device drives data out
                nxt_dout       = i_rdata;
                // R9 enable only while selected read
                nxt_doe        = 1'b1;
            end
            host_port_pkg::ACC_IDLE: begin
                nxt_doe = 1'b0;
            end
        endcase
        // R8 any pending source pulls low
        nxt_irq_oe = |i_irq_src;
        // R8 level low while pending
        nxt_irq_n  = ~(|i_irq_src);
    end

    // Register every output so pins see no glitches
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            req_ff    <= '0;
            dout_ff   <= host_port_pkg::DATA_RST;
            doe_ff    <= 1'b0;
            irq_oe_ff <= 1'b0;
            irq_n_ff  <= 1'b1;
        end else begin
            req_ff    <= nxt_req;
            dout_ff   <= nxt_dout;
            doe_ff    <= nxt_doe;
            irq_oe_ff <= nxt_irq_oe;
            irq_n_ff  <= nxt_irq_n;
        end
    end

    assign o_data    = dout_ff;
    assign o_data_oe = doe_ff;
    // Open drain: level is low whenever the enable is high, so the
    // pin only ever pulls low; the high level is never driven
    assign o_irq_n   = irq_n_ff;
    assign o_irq_oe  = irq_oe_ff;
    assign o_wr_stb  = req_ff.wr_stb;
    assign o_rd_act  = req_ff.rd_act;
    assign o_addr    = req_ff.addr;
    assign o_wdata   = req_ff.wdata;

endmodule : host_bus_port

// [dv/host_port_properties.sv]
// ==========================================================
// Port timing checker
// ==========================================================
module host_port_properties #(
    parameter int IRQ_N = 8
) (
    input wire logic             i_core_clk,
    input wire logic             i_rst,
    input wire logic             i_cs_n,
    input wire logic             i_rw_wr_n,
    input wire logic [IRQ_N-1:0] i_irq_src,
    input wire logic             o_data_oe,
    input wire logic             o_irq_n,
    input wire logic             o_irq_oe,
    input wire logic             o_wr_stb,
    input wire logic             o_rd_act
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // Longer than the five-edge pin delay
    sequence cs_idle; i_cs_n [*7]; endsequence
    sequence irq_on; (|i_irq_src) [*3]; endsequence
    sequence irq_off; !(|i_irq_src) [*3]; endsequence
    wr_deselect_a: assert property (cs_idle |-> !o_wr_stb)
        else $error("write pulse while deselected");
    rd_deselect_a: assert property (cs_idle |-> !o_data_oe)
        else $error("bus driven while deselected");
    wr_single_a: assert property (o_wr_stb |=> !o_wr_stb)
        else $error("write pulse longer than a cycle");
    wr_cause_a: assert property (o_wr_stb |->
        !$past(i_rw_wr_n, 5) && !$past(i_cs_n, 5))
        else $error("write pulse without a write access");
    rd_cause_a: assert property ($rose(o_data_oe) |->
        $past(i_rw_wr_n, 5) && !$past(i_cs_n, 5))
        else $error("bus driven without a read access");
    oe_read_a: assert property (o_data_oe |-> o_rd_act && !o_wr_stb)
        else $error("bus driven outside a read");
    irq_set_a: assert property (irq_on |-> o_irq_oe && !o_irq_n)
        else $error("interrupt not pulled low");
    irq_clear_a: assert property (irq_off |-> !o_irq_oe)
        else $error("interrupt held with none pending");
endmodule : host_port_properties

bind host_bus_port host_port_properties #(.IRQ_N(IRQ_N)) u_props (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_cs_n(i_cs_n),
    .i_rw_wr_n(i_rw_wr_n), .i_irq_src(i_irq_src),
    .o_data_oe(o_data_oe), .o_irq_n(o_irq_n), .o_irq_oe(o_irq_oe),
    .o_wr_stb(o_wr_stb), .o_rd_act(o_rd_act));

// [dv/proc_bus_model.sv]
// ==========================================================
// Local processor driving the port pins
// ==========================================================
module proc_bus_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_style,
    input  wire logic        i_data_oe,
    input  wire logic [15:0] i_bus,
    output logic             o_cs_n,
    output logic             o_rw_wr_n,
    output logic             o_oe_rd_n,
    output logic [11:0]      o_addr,
    output logic [15:0]      o_data,
    output logic             o_drive
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pins start idle so the first edge after reset sees no access
    initial begin
        o_cs_n    = 1'b1;
        o_rw_wr_n = 1'b1;
        o_oe_rd_n = 1'b0;
        o_addr    = 12'h000;
        o_data    = 16'h0000;
        o_drive   = 1'b0;
    end
    // Park the enable or read strobe at the idle level of the style
    task automatic park();
        @(negedge i_core_clk);
        o_oe_rd_n <= i_style;
    endtask : park
    // One access; pins held well past the sync delay
    task automatic acc(input logic wr, input logic sel,
        input logic [11:0] a, inout logic [15:0] d, output bit late);
        int n;
        n = 0;
        late = 0;
        @(negedge i_core_clk);
        o_cs_n    <= !sel;
        o_addr    <= a;
        o_data    <= wr ? d : ~o_data;
        o_drive   <= wr;
        o_rw_wr_n <= !wr;
        o_oe_rd_n <= i_style ? wr : 1'b0;
        repeat (7) @(negedge i_core_clk);
        if (!wr && sel) begin
            while (!i_data_oe && n < 20) begin
                @(negedge i_core_clk);
                n++;
            end
            late = (n == 20);
            repeat (2) @(negedge i_core_clk);
            d = i_bus;
        end
        // Released lines flip so stale data never looks valid
        o_cs_n    <= 1'b1;
        o_rw_wr_n <= 1'b1;
        o_oe_rd_n <= i_style;
        o_drive   <= 1'b0;
        o_data    <= ~o_data;
        // Turnaround: the port keeps driving five edges after a read
        repeat (6) @(negedge i_core_clk);
    endtask : acc
endmodule : proc_bus_model

// [dv/host_bus_port_tb.sv]
module host_bus_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk = 0, rst = 1, style = 0;
    logic        cs_n, rw_wr_n, oe_rd_n, drive, data_oe, irq_n;
    logic        irq_oe, wr_stb, rd_act, irq_w;
    logic [11:0] p_addr, o_addr;
    logic [15:0] p_data, bus, o_data, o_wdata, rdata;
    logic [15:0] regs [0:4095];
    logic [7:0]  irq_src = 8'h00;
    int          err_total, comparisons, wr_seen;
    int          exp_mem [int];
    always #2.5 core_clk = ~core_clk;
    // Wire levels: bus shared, interrupt pulled up
    assign bus   = data_oe ? o_data : p_data;
    assign irq_w = irq_oe ? irq_n : 1'b1;
    assign rdata = regs[o_addr];
    host_bus_port i_host_bus_port (.i_core_clk(core_clk), .i_rst(rst),
        .i_style(style), .i_cs_n(cs_n), .i_rw_wr_n(rw_wr_n),
        .i_oe_rd_n(oe_rd_n), .i_addr(p_addr), .i_data(bus),
        .i_rdata(rdata), .i_irq_src(irq_src), .o_data(o_data),
        .o_data_oe(data_oe), .o_irq_n(irq_n), .o_irq_oe(irq_oe),
        .o_wr_stb(wr_stb), .o_rd_act(rd_act), .o_addr(o_addr),
        .o_wdata(o_wdata));
    proc_bus_model u_proc (.i_core_clk(core_clk), .i_style(style),
        .i_data_oe(data_oe), .i_bus(bus), .o_cs_n(cs_n),
        .o_rw_wr_n(rw_wr_n), .o_oe_rd_n(oe_rd_n), .o_addr(p_addr),
        .o_data(p_data), .o_drive(drive));
    // Register side of the device
    always @(posedge core_clk) begin
        if (wr_stb) begin
            regs[o_addr] <= o_wdata;
            wr_seen <= wr_seen + 1;
        end
        if (data_oe && drive) check(16'h1, 16'h0);
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    // One access compared against the reference memory
    task automatic xfer(input logic wr, input logic sel,
        input logic [11:0] a, input logic [15:0] d);
        logic [15:0] v;
        bit late;
        int w0;
        v = d;
        w0 = wr_seen;
        u_proc.acc(wr, sel, a, v, late);
        if (late) begin
            err_total++;
            report_and_stop();
        end
        if (wr && sel) exp_mem[a] = d;
        if (wr) check(16'(wr_seen - w0), {15'h0, sel});
        else if (sel) check(v, 16'(exp_mem[a]));
        if (exp_mem.exists(a)) check(regs[a], 16'(exp_mem[a]));
    endtask : xfer
    initial begin
        logic [11:0] a;
        err_total = 0; comparisons = 0; wr_seen = 0;
        void'($urandom(32'hE9195249));
        repeat (20) @(posedge core_clk);
        @(negedge core_clk) rst <= 0;
        for (int s = 0; s < 2; s++) begin
            @(negedge core_clk) style <= s[0];
            u_proc.park();
            repeat (4) @(negedge core_clk);
            for (int k = 0; k < 4; k++) begin
                a = 12'($urandom);
                xfer(1, 1, a, 16'($urandom));
                xfer(1, 1, a, 16'($urandom));
                xfer(0, 1, a, 16'h0000);
                xfer(1, 0, a, 16'($urandom));
                xfer(0, 0, a, 16'h0000);
                xfer(0, 1, a, 16'h0000);
            end
            $display("test style %0d done", s);
        end
        for (int i = 0; i < 6; i++) begin
            @(negedge core_clk) irq_src <= i[0] ? 8'($urandom | 1) : 8'h00;
            repeat (4) @(negedge core_clk);
            check({15'h0, irq_w}, {15'h0, irq_src == 8'h00});
        end
        $display("test interrupt done");
        report_and_stop();
    end
endmodule : host_bus_port_tb
